/* design/cfgap_consts.svh */
// constants of the configuration register access port
`ifndef CFGAP_CONSTS_SVH
`define CFGAP_CONSTS_SVH
`define CFGAP_TOK_WRITE   8'hC0
`define CFGAP_TOK_READ    8'hC1
`define CFGAP_TOK_END     8'h01
`define CFGAP_TOK_ACK     8'h03
`define CFGAP_TOK_NACK    8'h04
`define CFGAP_NOREPLY     8'hFF
`define CFGAP_PS_TAG      8'h0B
`define CFGAP_HDR_BYTES   3'h5
`define CFGAP_DATA_BYTES  3'h4
`define CFGAP_RD_STEPS    3'h6
`define CFGAP_SHORT_STEPS 3'h2
`define CFGAP_REG_RESET   32'h0000_0000
`endif

/* design/cfgap_pkg.sv */
// types of the configuration register access port
package cfgap_pkg;
    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } cfgap_tok_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] resid;
        logic [31:0] wdata;
    } cfgap_ps_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HDR   = 3'b001,
        ST_DATA  = 3'b010,
        ST_EOM   = 3'b011,
        ST_DRAIN = 3'b100,
        ST_EXEC  = 3'b101,
        ST_REPLY = 3'b110
    } cfgap_state_t;
endpackage : cfgap_pkg

/* design/cfgap_regbank.sv */
// configuration register bank, register 0 read-only status
`timescale 1ns/1ps
`include "cfgap_consts.svh"
module cfgap_regbank #(
    parameter int NUM_REGS = 8
) (
    input  wire logic                     i_mclk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_en,
    input  wire logic                     i_we,
    input  wire logic [15:0]              i_addr,
    input  wire logic [31:0]              i_wdata,
    input  wire logic [31:0]              i_stat,
    output logic      [31:0]              o_rdata,
    output logic                          o_hit,
    output logic      [NUM_REGS*32-1:0]   o_regs
);
    logic [31:0] regs_q [NUM_REGS];
    logic        in_range;

    assign in_range = (i_addr < 16'(NUM_REGS));
    // writes to the status word are refused, reads of it see live state
    assign o_hit   = in_range && !(i_we && (i_addr == 16'h0000));
    assign o_rdata = !in_range ? 32'h0000_0000 :
                     (i_addr == 16'h0000) ? i_stat : regs_q[i_addr[$clog2(NUM_REGS)-1:0]];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= `CFGAP_REG_RESET;
            end
        end else if (i_en && i_we && o_hit) begin
            regs_q[i_addr[$clog2(NUM_REGS)-1:0]] <= i_wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            o_regs[i*32 +: 32] = (i == 0) ? i_stat : regs_q[i];
        end
    end
endmodule : cfgap_regbank

/* design/cfgap_top.sv */
// token-message access port to the tile configuration registers
`timescale 1ns/1ps
`include "cfgap_consts.svh"
module cfgap_top #(
    parameter int NUM_REGS = 8
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_resetn,
    input  wire logic                       i_rx_valid,
    input  wire cfgap_pkg::cfgap_tok_t      i_rx_tok,
    output logic                            o_rx_ready,
    output logic                            o_tx_valid,
    output cfgap_pkg::cfgap_tok_t           o_tx_tok,
    output logic      [23:0]                o_tx_dest,
    input  wire logic                       i_tx_ready,
    input  wire cfgap_pkg::cfgap_ps_req_t   i_ps,
    output logic                            o_ps_ack,
    output logic                            o_ps_err,
    output logic      [31:0]                o_ps_rdata,
    output logic      [NUM_REGS*32-1:0]     o_cfg_regs
);
    cfgap_pkg::cfgap_state_t state_q;
    cfgap_pkg::cfgap_state_t state_d;
    logic        is_wr_q;
    logic        err_q;
    logic        ok_q;
    logic [2:0]  cnt_q;
    logic [2:0]  step_q;
    logic [39:0] hdr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [15:0] done_cnt_q;
    logic [15:0] fail_cnt_q;
    logic        acc;
    logic        use_cfg;
    logic        suppress;
    logic        ps_take;
    logic        ps_tag_ok;
    logic        tx_load;
    logic        last_step;
    logic        bank_en;
    logic        bank_we;
    logic [15:0] bank_addr;
    logic [31:0] bank_wdata;
    logic [31:0] bank_rdata;
    logic        bank_hit;

    assign acc       = i_rx_valid && o_rx_ready;
    assign use_cfg   = (state_q == cfgap_pkg::ST_EXEC);
    assign suppress  = is_wr_q && (hdr_q[23:16] == `CFGAP_NOREPLY);
    assign ps_tag_ok = (i_ps.resid[7:0] == `CFGAP_PS_TAG);
    // status access waits one cycle while a message uses the bank
    assign ps_take   = i_ps.req && !o_ps_ack && !use_cfg;
    assign tx_load   = (state_q == cfgap_pkg::ST_REPLY) && (!o_tx_valid || i_tx_ready);
    assign last_step = (step_q == ((ok_q && !is_wr_q) ? `CFGAP_RD_STEPS : `CFGAP_SHORT_STEPS) - 3'h1);

    assign bank_en    = use_cfg ? !err_q : (ps_take && ps_tag_ok);
    assign bank_we    = use_cfg ? is_wr_q : i_ps.we;
    assign bank_addr  = use_cfg ? hdr_q[15:0] : {8'h00, i_ps.resid[15:8]};
    assign bank_wdata = use_cfg ? wdata_q : i_ps.wdata;

    cfgap_regbank #(
        .NUM_REGS (NUM_REGS)
    ) u_bank (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_en     (bank_en),
        .i_we     (bank_we),
        .i_addr   (bank_addr),
        .i_wdata  (bank_wdata),
        .i_stat   ({fail_cnt_q, done_cnt_q}),
        .o_rdata  (bank_rdata),
        .o_hit    (bank_hit),
        .o_regs   (o_cfg_regs)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cfgap_pkg::ST_IDLE: begin
                if (acc && i_rx_tok.ctrl &&
                    (i_rx_tok.data == `CFGAP_TOK_WRITE || i_rx_tok.data == `CFGAP_TOK_READ)) begin
                    state_d = cfgap_pkg::ST_HDR;
                end
            end
            cfgap_pkg::ST_HDR, cfgap_pkg::ST_DATA: begin
                if (acc && i_rx_tok.ctrl) begin
                    // short message: fail at once if it closed, otherwise skip to its end
                    state_d = (i_rx_tok.data == `CFGAP_TOK_END) ? cfgap_pkg::ST_EXEC : cfgap_pkg::ST_DRAIN;
                end else if (acc && state_q == cfgap_pkg::ST_HDR && cnt_q == `CFGAP_HDR_BYTES - 3'h1) begin
                    state_d = is_wr_q ? cfgap_pkg::ST_DATA : cfgap_pkg::ST_EOM;
                end else if (acc && state_q == cfgap_pkg::ST_DATA && cnt_q == `CFGAP_DATA_BYTES - 3'h1) begin
                    state_d = cfgap_pkg::ST_EOM;
                end
            end
            cfgap_pkg::ST_EOM: begin
                if (acc) begin
                    state_d = (i_rx_tok.ctrl && i_rx_tok.data == `CFGAP_TOK_END) ?
                              cfgap_pkg::ST_EXEC : cfgap_pkg::ST_DRAIN;
                end
            end
            cfgap_pkg::ST_DRAIN: begin
                if (acc && i_rx_tok.ctrl && i_rx_tok.data == `CFGAP_TOK_END) begin
                    state_d = cfgap_pkg::ST_EXEC;
                end
            end
            cfgap_pkg::ST_EXEC: begin
                state_d = suppress ? cfgap_pkg::ST_IDLE : cfgap_pkg::ST_REPLY;
            end
            cfgap_pkg::ST_REPLY: begin
                if (tx_load && last_step) begin
                    state_d = cfgap_pkg::ST_IDLE;
                end
            end
            default: state_d = cfgap_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q    <= cfgap_pkg::ST_IDLE;
            o_rx_ready <= 1'b0;
        end else begin
            state_q    <= state_d;
            o_rx_ready <= (state_d inside {cfgap_pkg::ST_IDLE, cfgap_pkg::ST_HDR, cfgap_pkg::ST_DATA,
                                           cfgap_pkg::ST_EOM, cfgap_pkg::ST_DRAIN});
        end
    end

    // message parse: kind, byte count, fields, error
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            is_wr_q <= 1'b0;
            err_q   <= 1'b0;
            cnt_q   <= 3'h0;
            hdr_q   <= 40'h00_0000_0000;
            wdata_q <= 32'h0000_0000;
        end else if (acc) begin
            if (state_q == cfgap_pkg::ST_IDLE) begin
                is_wr_q <= (i_rx_tok.data == `CFGAP_TOK_WRITE);
                err_q   <= 1'b0;
                cnt_q   <= 3'h0;
            end else begin
                if (state_d == cfgap_pkg::ST_DRAIN ||
                    (state_d == cfgap_pkg::ST_EXEC && state_q != cfgap_pkg::ST_EOM &&
                     state_q != cfgap_pkg::ST_DRAIN)) begin
                    err_q <= 1'b1;
                end
                cnt_q <= (state_d != state_q) ? 3'h0 : cnt_q + 3'h1;
                if (!i_rx_tok.ctrl && state_q == cfgap_pkg::ST_HDR) begin
                    hdr_q <= {hdr_q[31:0], i_rx_tok.data};
                end
                if (!i_rx_tok.ctrl && state_q == cfgap_pkg::ST_DATA) begin
                    wdata_q <= {wdata_q[23:0], i_rx_tok.data};
                end
            end
        end
    end

    // execute and counters kept in the status word
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ok_q       <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            done_cnt_q <= 16'h0000;
            fail_cnt_q <= 16'h0000;
        end else if (use_cfg) begin
            ok_q    <= !err_q && bank_hit;
            rdata_q <= bank_rdata;
            if (!err_q && bank_hit) begin
                done_cnt_q <= done_cnt_q + 16'h0001;
            end else begin
                fail_cnt_q <= fail_cnt_q + 16'h0001;
            end
        end else if (tx_load && step_q != 3'h0 && !last_step) begin
            rdata_q <= {rdata_q[23:0], 8'h00};
        end
    end

    // reply tokens; held until the channel takes them
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            step_q     <= 3'h0;
            o_tx_valid <= 1'b0;
            o_tx_tok   <= '0;
            o_tx_dest  <= 24'h00_0000;
        end else begin
            if (use_cfg) begin
                step_q <= 3'h0;
            end else if (tx_load) begin
                step_q     <= step_q + 3'h1;
                o_tx_valid <= 1'b1;
                o_tx_dest  <= hdr_q[39:16];
                if (step_q == 3'h0) begin
                    o_tx_tok <= {1'b1, ok_q ? `CFGAP_TOK_ACK : `CFGAP_TOK_NACK};
                end else if (last_step) begin
                    o_tx_tok <= {1'b1, `CFGAP_TOK_END};
                end else begin
                    o_tx_tok <= {1'b0, rdata_q[31:24]};
                end
            end else if (i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
        end
    end

    // processor status read and write
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ps_ack   <= 1'b0;
            o_ps_err   <= 1'b0;
            o_ps_rdata <= 32'h0000_0000;
        end else begin
            o_ps_ack <= ps_take;
            if (ps_take) begin
                o_ps_err   <= !ps_tag_ok || !bank_hit;
                o_ps_rdata <= (ps_tag_ok && bank_hit && !i_ps.we) ? bank_rdata : 32'h0000_0000;
            end
        end
    end

    AST_WR_OPEN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        state_q == cfgap_pkg::ST_IDLE && acc && i_rx_tok.ctrl && i_rx_tok.data == `CFGAP_TOK_WRITE
        |=> state_q == cfgap_pkg::ST_HDR && is_wr_q) else $error("write open token not taken");
    AST_RD_NO_DATA: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        state_q == cfgap_pkg::ST_HDR && !is_wr_q && acc && !i_rx_tok.ctrl && cnt_q == 3'h4
        |=> state_q == cfgap_pkg::ST_EOM) else $error("read expected data field");
    AST_FIRST_TOKEN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        tx_load && step_q == 3'h0
        |=> o_tx_valid && o_tx_tok == {1'b1, $past(ok_q) ? `CFGAP_TOK_ACK : `CFGAP_TOK_NACK})
        else $error("wrong first reply token");
    AST_READ_WORD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        tx_load && step_q == 3'h1 && ok_q && !is_wr_q
        |=> !o_tx_tok.ctrl && o_tx_tok.data == $past(rdata_q[31:24])) else $error("read data byte wrong");
    AST_SUPPRESS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        use_cfg && is_wr_q && hdr_q[23:16] == 8'hFF
        |=> state_q == cfgap_pkg::ST_IDLE ##1 state_q != cfgap_pkg::ST_REPLY)
        else $error("suppressed write replied");
    AST_BAD_REG: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        use_cfg && hdr_q[15:0] >= 16'(NUM_REGS) |=> !ok_q) else $error("unknown register succeeded");
    AST_CTRL_APART: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        state_q == cfgap_pkg::ST_DATA && acc && i_rx_tok.ctrl |=> state_q != cfgap_pkg::ST_DATA && err_q)
        else $error("control token taken as data");
    AST_PS_TAG: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ps_take && i_ps.resid[7:0] != 8'h0B |=> o_ps_ack && o_ps_err) else $error("bad resource id accepted");
    AST_PS_WORD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ps_take && ps_tag_ok && bank_hit && !i_ps.we |=> o_ps_rdata == $past(bank_rdata) && !o_ps_err)
        else $error("status read word wrong");
    AST_MSB_FIRST: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        state_q == cfgap_pkg::ST_DATA && acc && !i_rx_tok.ctrl |=> wdata_q[7:0] == $past(i_rx_tok.data))
        else $error("data byte order wrong");

    COV_WRITE_OK: cover property (@(posedge i_mclk) disable iff (!i_resetn) use_cfg && is_wr_q && bank_hit && !err_q);
    COV_READ_REPLY: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        tx_load && last_step && ok_q && !is_wr_q);
    COV_PS_WRITE: cover property (@(posedge i_mclk) disable iff (!i_resetn) ps_take && i_ps.we && ps_tag_ok);
endmodule : cfgap_top

/* test/cfgap_client.sv */
// requester and reply consumer model on the far side of the access port
`timescale 1ns/1ps
module cfgap_client (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rx_ready,
    output logic                       o_rx_valid,
    output cfgap_pkg::cfgap_tok_t      o_rx_tok,
    input  wire logic                  i_tx_valid,
    input  wire cfgap_pkg::cfgap_tok_t i_tx_tok,
    output logic                       o_tx_ready
);
    // destination a direct requester programs: tile id above the endpoint code
    localparam logic [31:0] PORT_DEST = {16'h0001, 16'hC20C};
    logic                  slow = 1'b0;
    cfgap_pkg::cfgap_tok_t got[$];

    initial begin
        o_rx_valid = 1'b0;
        o_rx_tok   = '0;
        o_tx_ready = 1'b0;
    end

    // slow mode drops ready on every other cycle
    always @(negedge i_mclk) o_tx_ready <= slow ? ~o_tx_ready : 1'b1;

    always @(posedge i_mclk) begin
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_tok);
        end
    end

    // entered at a falling edge; holds the token until an edge with ready high
    task send(input logic c, input logic [7:0] b);
        logic ok;
        o_rx_valid = 1'b1;
        o_rx_tok   = {c, b};
        do begin
            ok = i_rx_ready;
            @(negedge i_mclk);
        end while (ok !== 1'b1);
    endtask : send

    // nd data bytes, so a short write can be sent on purpose
    task msg(input logic wr, input logic [23:0] ret, input logic [15:0] rn, input logic [31:0] d, input int nd);
        send(1'b1, wr ? 8'hC0 : 8'hC1);
        for (int i = 2; i >= 0; i--) send(1'b0, ret[i*8+:8]);
        for (int i = 1; i >= 0; i--) send(1'b0, rn[i*8+:8]);
        for (int i = 3; i >= 4 - nd; i--) send(1'b0, d[i*8+:8]);
        send(1'b1, 8'h01);
        o_rx_valid = 1'b0;
        o_rx_tok   = ~o_rx_tok; // released line must not look like the last token
    endtask : msg
endmodule : cfgap_client

/* test/tb_cfgap_top.sv */
// self-checking bench for the configuration register access port
`timescale 1ns/1ps
module tb_cfgap_top;
    localparam int NREG = 8;
    logic                     i_mclk   = 1'b0;
    logic                     i_resetn = 1'b0;
    logic                     rx_valid, rx_ready, tx_valid, tx_ready, ps_ack, ps_err;
    cfgap_pkg::cfgap_tok_t    rx_tok, tx_tok;
    cfgap_pkg::cfgap_ps_req_t ps = '0;
    logic [23:0]              tx_dest, last_dest;
    logic [31:0]              ps_rdata;
    logic [NREG*32-1:0]       cfg_regs;
    logic [8:0]               exp[$];
    int                       mismatches  = 0;
    int                       check_count = 0;
    int                       cycles      = 0;

    always #10 i_mclk = ~i_mclk;

    cfgap_top #(.NUM_REGS(NREG)) dut_u (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_rx_valid(rx_valid), .i_rx_tok(rx_tok),
        .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_tok(tx_tok), .o_tx_dest(tx_dest),
        .i_tx_ready(tx_ready), .i_ps(ps), .o_ps_ack(ps_ack), .o_ps_err(ps_err),
        .o_ps_rdata(ps_rdata), .o_cfg_regs(cfg_regs));

    cfgap_client peer_u (
        .i_mclk(i_mclk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid), .o_rx_tok(rx_tok),
        .i_tx_valid(tx_valid), .i_tx_tok(tx_tok), .o_tx_ready(tx_ready));

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // waits for the queued number of reply tokens, then compares them in order
    task wait_reply();
        for (int i = 0; i < 200 && peer_u.got.size() < exp.size(); i++) begin
            if (tx_valid === 1'b1) last_dest = tx_dest;
            @(negedge i_mclk);
        end
        chk("reply count", exp.size(), peer_u.got.size());
        foreach (exp[i]) if (i < peer_u.got.size()) chk("reply token", {23'h0, exp[i]}, {23'h0, peer_u.got[i]});
        exp.delete();
        peer_u.got.delete();
    endtask : wait_reply

    task ps_op(input logic we, input logic [15:0] rid, input logic [31:0] d, input logic e, input logic [31:0] r);
        int i;
        ps = {1'b1, we, rid, d};
        for (i = 0; i < 50 && ps_ack !== 1'b1; i++) @(negedge i_mclk);
        ps.req = 1'b0;
        chk("status error flag", {31'h0, e}, {31'h0, ps_err});
        chk("status read word", r, ps_rdata);
        @(negedge i_mclk);
    endtask : ps_op

    task t_write_read();
        peer_u.msg(1'b1, 24'h123456, 16'h0001, 32'hA5C30F81, 4);
        exp = '{9'h103, 9'h101};
        wait_reply();
        chk("register 1", 32'hA5C30F81, cfg_regs[63:32]);
        peer_u.slow = 1'b1;
        peer_u.msg(1'b0, 24'h654321, 16'h0001, 32'h0, 0);
        exp = '{9'h103, 9'h0A5, 9'h0C3, 9'h00F, 9'h081, 9'h101};
        wait_reply();
        chk("reply destination", 32'h654321, {8'h0, last_dest});
        peer_u.slow = 1'b0;
        $display("test write_read done");
    endtask : t_write_read

    task t_noreply();
        peer_u.msg(1'b1, 24'h0102FF, 16'h0002, 32'h12345678, 4);
        repeat (20) @(negedge i_mclk);
        wait_reply();
        chk("register 2", 32'h12345678, cfg_regs[95:64]);
        $display("test noreply done");
    endtask : t_noreply

    task t_fail();
        peer_u.msg(1'b0, 24'h0A0B0C, 16'h0009, 32'h0, 0);
        exp = '{9'h104, 9'h101};
        wait_reply();
        peer_u.msg(1'b1, 24'hABCD01, 16'h0003, 32'hFFEE0000, 2);
        exp = '{9'h104, 9'h101};
        wait_reply();
        chk("register 3 kept", 32'h0, cfg_regs[127:96]);
        peer_u.send(1'b1, 8'h01);
        peer_u.msg(1'b0, 24'h0A0B0D, 16'h0001, 32'h7700_0000, 1);
        exp = '{9'h104, 9'h101};
        wait_reply();
        $display("test fail done");
    endtask : t_fail

    task t_ps();
        chk("status word", 32'h0003_0003, cfg_regs[31:0]);
        ps_op(1'b0, 16'h000B, 32'h0, 1'b0, 32'h0003_0003);
        ps_op(1'b1, 16'h000B, 32'h1, 1'b1, 32'h0);
        ps_op(1'b0, 16'h010B, 32'h0, 1'b0, 32'hA5C30F81);
        ps_op(1'b1, 16'h030B, 32'hDEADBEEF, 1'b0, 32'h0);
        chk("register 3", 32'hDEADBEEF, cfg_regs[127:96]);
        ps_op(1'b0, 16'h0102, 32'h0, 1'b1, 32'h0);
        $display("test status done");
    endtask : t_ps

    task give_verdict();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // whole run needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (2) @(negedge i_mclk);
        t_write_read();
        t_noreply();
        t_fail();
        t_ps();
        give_verdict();
    end
endmodule : tb_cfgap_top
